/* inc/alu_flags_pkg.sv */
// Package with the flag register layout, ALU operation codes and bus constants.
package alu_flags_pkg;

  localparam int FlagWidth = 8;
  localparam int CarryBit = 0;
  localparam int NibbleCarryBit = 1;
  localparam int ZeroBit = 2;
  localparam int OverrunBit = 3;
  localparam int NegativeBit = 4;
  localparam logic [7:0] ImplMask = 8'h1f;
  localparam logic [7:0] FlagsReset = 8'h00;
  localparam int NibbleTop = 3;
  localparam int SignBit = 7;

  // Register map on the AXI4-Lite bus.
  localparam logic [7:0] FlagsAddr = 8'h00;
  localparam logic [7:0] OperandAAddr = 8'h04;
  localparam logic [7:0] OperandBAddr = 8'h08;
  localparam logic [7:0] CommandAddr = 8'h0c;
  localparam logic [7:0] ResultAddr = 8'h10;
  localparam logic [1:0] RespOkay = 2'h0;
  localparam logic [1:0] RespSlvErr = 2'h2;

  // Command register fields.
  localparam int OpLsb = 0;
  localparam int OpMsb = 3;
  localparam int DestFlagsBit = 8;
  localparam int BitSelLsb = 4;
  localparam int BitSelMsb = 6;

  typedef enum logic [3:0] {
    add_reg_op = 4'h0,
    add_literal_op = 4'h1,
    sub_from_literal_op = 4'h2,
    sub_reg_op = 4'h3,
    and_op = 4'h4,
    or_op = 4'h5,
    xor_op = 4'h6,
    clear_file_op = 4'h7,
    bit_clear_op = 4'h8,
    bit_set_op = 4'h9,
    nibble_swap_op = 4'ha,
    file_to_file_move_op = 4'hb,
    move_from_w_op = 4'hc
  } alu_op_t;

  typedef struct packed {
    logic negative;
    logic signedOverrun;
    logic zero;
    logic nibbleCarry;
    logic carry;
  } flags_t;

endpackage : alu_flags_pkg

/* src/alu_status_flags.sv */
// Arithmetic status flag register with a small ALU, reached over AXI4-Lite.
//
// Contract
// - The flag register is readable and writable like any register; bits 7..5 read as zero.
// - A flag-changing operation aimed at the flag register drops its result and only sets flags.
// - Clearing the flag register sets zero and leaves the other flags unchanged.
// - Bit clear, bit set, swap and both moves change no flag and write the register as told.
// - Negative in bit 4 copies the result's top bit for the add, subtract and logic operations.
// - Overflow in bit 3 is set when a signed operation makes the sign bit change wrongly.
// - Digit carry in bit 1 is the carry out of bit 3 for the add and subtract operations.
// - Carry in bit 0 is the carry out of bit 7; in subtraction both carries are inverted borrows.
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
module alu_status_flags (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Flags to the core
  output alu_flags_pkg::flags_t flagsOut
);

  logic rstMeta_reg;
  logic rstSync_reg;
  logic rstn;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end
  assign rstn = rstSync_reg;

  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] opA_reg;
  logic [7:0] opB_reg;
  logic [7:0] result_reg;
  logic [7:0] result_next;

  // Write channel capture; address and data may arrive in either order.
  logic awHeld_reg;
  logic wHeld_reg;
  logic [7:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic doWrite;

  assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= 1'b0;
      if (doWrite) begin
        awHeld_reg <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end else if (s_axi_awvalid && !awHeld_reg) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wHeld_reg <= 1'b0;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= 1'b0;
      if (doWrite) begin
        wHeld_reg <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end else if (s_axi_wvalid && !wHeld_reg) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  logic addrKnown;
  assign addrKnown = (awAddr_reg == alu_flags_pkg::FlagsAddr) ||
                     (awAddr_reg == alu_flags_pkg::OperandAAddr) ||
                     (awAddr_reg == alu_flags_pkg::OperandBAddr) ||
                     (awAddr_reg == alu_flags_pkg::CommandAddr) ||
                     (awAddr_reg == alu_flags_pkg::ResultAddr);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= alu_flags_pkg::RespOkay;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addrKnown ? alu_flags_pkg::RespOkay : alu_flags_pkg::RespSlvErr;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Executing the command: operand A and operand B, or the flag register when it is the target; subtract-from-literal and file-to-file move always use operand B.
  logic cmdGo;
  alu_flags_pkg::alu_op_t op;
  logic toFlags;
  logic [2:0] bitSel;
  assign cmdGo = doWrite && wStrb_reg[0] && (awAddr_reg == alu_flags_pkg::CommandAddr);
  assign op = alu_flags_pkg::alu_op_t'(wData_reg[alu_flags_pkg::OpMsb:alu_flags_pkg::OpLsb]);
  assign toFlags = wData_reg[alu_flags_pkg::DestFlagsBit];
  assign bitSel = wData_reg[alu_flags_pkg::BitSelMsb:alu_flags_pkg::BitSelLsb];

  always_comb begin
    logic [8:0] sum;
    logic [4:0] lowSum;
    logic [7:0] addend;
    logic [7:0] target;
    logic [7:0] res;
    logic arith;
    logic logic8;
    logic noFlags;
    logic [7:0] augend;
    sum = 9'h000;
    lowSum = 5'h00;
    addend = 8'h00;
    arith = 1'b0;
    logic8 = 1'b0;
    noFlags = 1'b0;
    augend = opA_reg;
    // The operation's file operand is the flag register itself when it is the target.
    target = toFlags ? (flags_reg & alu_flags_pkg::ImplMask) : opB_reg;
    res = 8'h00;
    flags_next = flags_reg;
    result_next = result_reg;
    case (op)
      alu_flags_pkg::add_reg_op, alu_flags_pkg::add_literal_op: begin
        addend = target;
        arith = 1'b1;
      end
      alu_flags_pkg::sub_from_literal_op, alu_flags_pkg::sub_reg_op: begin
        addend = ~opA_reg;
        arith = 1'b1;
      end
      alu_flags_pkg::and_op: begin
        res = opA_reg & target;
        logic8 = 1'b1;
      end
      alu_flags_pkg::or_op: begin
        res = opA_reg | target;
        logic8 = 1'b1;
      end
      alu_flags_pkg::xor_op: begin
        res = opA_reg ^ target;
        logic8 = 1'b1;
      end
      alu_flags_pkg::clear_file_op: begin
        res = 8'h00;
      end
      alu_flags_pkg::bit_clear_op: begin
        res = target & ~(8'h01 << bitSel);
        noFlags = 1'b1;
      end
      alu_flags_pkg::bit_set_op: begin
        res = target | (8'h01 << bitSel);
        noFlags = 1'b1;
      end
      alu_flags_pkg::nibble_swap_op: begin
        res = {target[3:0], target[7:4]};
        noFlags = 1'b1;
      end
      alu_flags_pkg::file_to_file_move_op: begin
        res = opB_reg;
        noFlags = 1'b1;
      end
      alu_flags_pkg::move_from_w_op: begin
        res = opA_reg;
        noFlags = 1'b1;
      end
      default: begin
        noFlags = 1'b1;
        // An unknown code leaves its destination as it was, so no stale result leaks into the flags.
        res = toFlags ? target : result_reg;
      end
    endcase
    if (arith) begin
      // Subtraction adds the two's complement, so carries come out as inverted borrows.
      if (op == alu_flags_pkg::sub_from_literal_op || op == alu_flags_pkg::sub_reg_op) begin
        augend = (op == alu_flags_pkg::sub_reg_op) ? target : opB_reg;
        sum = {1'b0, augend} + {1'b0, addend} + 9'h001;
        lowSum = {1'b0, augend[3:0]} + {1'b0, addend[3:0]} + 5'h01;
      end else begin
        sum = {1'b0, opA_reg} + {1'b0, addend};
        lowSum = {1'b0, opA_reg[3:0]} + {1'b0, addend[3:0]};
      end
      res = sum[7:0];
      flags_next[alu_flags_pkg::CarryBit] = sum[8];
      flags_next[alu_flags_pkg::NibbleCarryBit] = lowSum[4];
      flags_next[alu_flags_pkg::OverrunBit] =
        (augend[alu_flags_pkg::SignBit] ~^ addend[alu_flags_pkg::SignBit]) &&
        (res[alu_flags_pkg::SignBit] != augend[alu_flags_pkg::SignBit]);
      flags_next[alu_flags_pkg::NegativeBit] = res[alu_flags_pkg::SignBit];
    end else if (logic8) begin
      flags_next[alu_flags_pkg::NegativeBit] = res[alu_flags_pkg::SignBit];
    end
    if (!noFlags) begin
      flags_next[alu_flags_pkg::ZeroBit] = (res == 8'h00);
    end
    if (toFlags && noFlags) begin
      flags_next = res & alu_flags_pkg::ImplMask;
    end else if (!toFlags) begin
      result_next = res;
    end
    // A flag-changing operation aimed at the flags keeps only the flag update.
    flags_next = flags_next & alu_flags_pkg::ImplMask;
  end

  // Register writes: plain stores and command execution.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flags_reg <= alu_flags_pkg::FlagsReset;
      opA_reg <= 8'h00;
      opB_reg <= 8'h00;
      result_reg <= 8'h00;
    end else if (cmdGo) begin
      flags_reg <= flags_next;
      result_reg <= result_next;
    end else if (doWrite && wStrb_reg[0]) begin
      case (awAddr_reg)
        alu_flags_pkg::FlagsAddr: flags_reg <= wData_reg[7:0] & alu_flags_pkg::ImplMask;
        alu_flags_pkg::OperandAAddr: opA_reg <= wData_reg[7:0];
        alu_flags_pkg::OperandBAddr: opB_reg <= wData_reg[7:0];
        default: begin
        end
      endcase
    end
  end

  // Read channel.
  logic [31:0] readWord;
  logic readKnown;
  always_comb begin
    readWord = 32'h0000_0000;
    readKnown = 1'b1;
    case (s_axi_araddr)
      alu_flags_pkg::FlagsAddr: readWord = {24'h000000, flags_reg & alu_flags_pkg::ImplMask};
      alu_flags_pkg::OperandAAddr: readWord = {24'h000000, opA_reg};
      alu_flags_pkg::OperandBAddr: readWord = {24'h000000, opB_reg};
      alu_flags_pkg::CommandAddr: readWord = 32'h0000_0000;
      alu_flags_pkg::ResultAddr: readWord = {24'h000000, result_reg};
      default: readKnown = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= alu_flags_pkg::RespOkay;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= readWord;
        s_axi_rresp <= readKnown ? alu_flags_pkg::RespOkay : alu_flags_pkg::RespSlvErr;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flagsOut <= '0;
    end else begin
      flagsOut <= alu_flags_pkg::flags_t'(flags_next[4:0]);
      if (!cmdGo) begin
        flagsOut <= alu_flags_pkg::flags_t'(flags_reg[4:0]);
      end
    end
  end

endmodule : alu_status_flags

/* sim/alu_status_flags_checker.sv */
// Concurrent checks on the bus and flag ports of the status flag block.
`timescale 1ns/100ps
module alu_status_flags_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // AXI4-Lite
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Flags
  input wire alu_flags_pkg::flags_t flagsOut
);
  logic [7:0] lastAw;
  logic [7:0] lastAr;
  logic [4:0] lastW;
  logic lastStrb;
  logic [3:0] sinceW;
  logic awOk;
  logic arOk;
  assign awOk = lastAw <= alu_flags_pkg::ResultAddr && lastAw[1:0] == 2'h0;
  assign arOk = lastAr <= alu_flags_pkg::ResultAddr && lastAr[1:0] == 2'h0;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lastAw <= 8'h00;
      lastAr <= 8'h00;
      lastW <= 5'h00;
      lastStrb <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) lastAw <= s_axi_awaddr;
      if (s_axi_arvalid && s_axi_arready) lastAr <= s_axi_araddr;
      if (s_axi_wvalid && s_axi_wready) lastW <= s_axi_wdata[4:0];
      if (s_axi_wvalid && s_axi_wready) lastStrb <= s_axi_wstrb[0];
    end
  end
  // Saturates so that a long quiet spell never wraps back into the window.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) sinceW <= 4'hf;
    else if (s_axi_wvalid && s_axi_wready) sinceW <= 4'h0;
    else if (sinceW != 4'hf) sinceW <= sinceW + 4'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_reset_quiet;
    $rose(rst_n) |-> !s_axi_bvalid && !s_axi_rvalid && !s_axi_awready && !s_axi_arready
      && flagsOut == alu_flags_pkg::FlagsReset[4:0];
  endproperty
  property p_read_time;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_write_time;
    s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid;
  endproperty
  property p_bresp;
    $rose(s_axi_bvalid) |->
      s_axi_bresp == (awOk ? alu_flags_pkg::RespOkay : alu_flags_pkg::RespSlvErr);
  endproperty
  property p_rresp;
    $rose(s_axi_rvalid) && lastAr != alu_flags_pkg::CommandAddr |->
      s_axi_rresp == (arOk ? alu_flags_pkg::RespOkay : alu_flags_pkg::RespSlvErr);
  endproperty
  property p_upper_zero;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  property p_flags_read;
    $rose(s_axi_rvalid) && lastAr == alu_flags_pkg::FlagsAddr |-> s_axi_rdata == {27'h0, flagsOut};
  endproperty
  property p_flags_write;
    $rose(s_axi_bvalid) && lastAw == alu_flags_pkg::FlagsAddr && lastStrb |->
      ##[0:2] flagsOut == lastW;
  endproperty
  property p_flags_quiet;
    !$stable(flagsOut) |-> sinceW < 4'h8;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  a_read_time: assert property (p_read_time) else $error("read answer late");
  a_write_time: assert property (p_write_time) else $error("write answer late");
  a_bresp: assert property (p_bresp) else $error("bad write response");
  a_rresp: assert property (p_rresp) else $error("bad read response");
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  a_flags_read: assert property (p_flags_read) else $error("flag read mismatch");
  a_flags_write: assert property (p_flags_write) else $error("flag write lost");
  a_flags_quiet: assert property (p_flags_quiet) else $error("flags moved unasked");
  c_flag_write: cover property ($rose(s_axi_bvalid) && lastAw == alu_flags_pkg::FlagsAddr);
  c_cmd_write: cover property ($rose(s_axi_bvalid) && lastAw == alu_flags_pkg::CommandAddr);
  c_error: cover property ($rose(s_axi_bvalid) && s_axi_bresp == alu_flags_pkg::RespSlvErr);
endmodule : alu_status_flags_checker
bind alu_status_flags alu_status_flags_checker u_checker (.*);

/* sim/alu_status_flags_bench.sv */
// Bus-level bench for the status flag block with a reference flag model.
`timescale 1ns/100ps
module alu_status_flags_bench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rd;
  alu_flags_pkg::flags_t flagsOut;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [4:0] fm;
  logic [12:0] ex;
  // Each entry is command, operand A, operand B; the last one is an unknown code aimed at the flags.
  logic [31:0] tbl [19] = '{32'h0000_017f, 32'h0001_01ff, 32'h0002_0505, 32'h0003_0100,
    32'h0003_0180, 32'h0004_0ff0, 32'h0005_8001, 32'h0006_aaaa, 32'h0007_0000,
    32'h0100_0100, 32'h0107_0000, 32'h0149_0000, 32'h0179_0000, 32'h0128_0000,
    32'h010a_0000, 32'h000b_0033, 32'h010c_1b00, 32'h0079_0000, 32'h010d_0000};
  alu_status_flags dut (.*);
  always #20 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      end_of_test();
    end
  end
  function automatic logic [12:0] model(input logic [15:0] cmd, input logic [7:0] a, b,
      input logic [4:0] f);
    logic [7:0] fo, x, r;
    logic [8:0] s;
    logic [4:0] h;
    logic cin;
    fo = cmd[8] ? {3'h0, f} : b;
    r = fo;
    cin = cmd[3:0] > 4'h1;
    x = cin ? ~a : a;
    s = {1'b0, fo} + {1'b0, x} + {8'h0, cin};
    h = {1'b0, fo[3:0]} + {1'b0, x[3:0]} + {4'h0, cin};
    case (cmd[3:0])
      4'h0, 4'h1, 4'h2, 4'h3: begin
        r = s[7:0];
        f = {s[7], (fo[7] == x[7]) && (s[7] != fo[7]), r == 8'h0, h[4], s[8]};
      end
      4'h4: r = a & fo;
      4'h5: r = a | fo;
      4'h6: r = a ^ fo;
      4'h7: r = 8'h0;
      4'h8: r[cmd[6:4]] = 1'b0;
      4'h9: r[cmd[6:4]] = 1'b1;
      4'ha: r = {fo[3:0], fo[7:4]};
      4'hc: r = a;
      default: ;
    endcase
    if (cmd[3:0] inside {4'h4, 4'h5, 4'h6}) f = {r[7], f[3], r == 8'h0, f[1:0]};
    if (cmd[3:0] == 4'h7) f[2] = 1'b1;
    if (cmd[8] && cmd[3:0] > 4'h7) f = r[4:0];
    return {r, f};
  endfunction : model
  task automatic check(input string name, input logic [31:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : check
  task automatic axi_write(input logic [7:0] addr, input logic [31:0] data,
      input logic [3:0] strb, output logic [1:0] resp);
    @(posedge clock);
    s_axi_awaddr <= addr;
    s_axi_wdata <= data;
    s_axi_wstrb <= strb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [7:0] addr, output logic [31:0] data,
      output logic [1:0] resp);
    @(posedge clock);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    check("reset flags", {27'h0, alu_flags_pkg::FlagsReset[4:0]}, {27'h0, flagsOut});
    axi_write(alu_flags_pkg::FlagsAddr, 32'hffff_ffff, 4'hf, rs);
    axi_read(alu_flags_pkg::FlagsAddr, rd, rs);
    check("flags all ones", {24'h0, alu_flags_pkg::ImplMask}, rd);
    // A write without lane 0 must leave the register alone.
    axi_write(alu_flags_pkg::FlagsAddr, 32'h0, 4'h0, rs);
    axi_read(alu_flags_pkg::FlagsAddr, rd, rs);
    check("flags no strobe", {24'h0, alu_flags_pkg::ImplMask}, rd);
    axi_write(8'h20, 32'h0, 4'hf, rs);
    check("unmapped bresp", {30'h0, alu_flags_pkg::RespSlvErr}, {30'h0, rs});
    axi_read(8'h20, rd, rs);
    check("unmapped rresp", {30'h0, alu_flags_pkg::RespSlvErr}, {30'h0, rs});
    fm = 5'h1f;
    for (int i = 0; i < 19; i++) begin
      ex = model(tbl[i][31:16], tbl[i][15:8], tbl[i][7:0], fm);
      fm = ex[4:0];
      axi_write(alu_flags_pkg::OperandAAddr, {24'h0, tbl[i][15:8]}, 4'hf, rs);
      axi_write(alu_flags_pkg::OperandBAddr, {24'h0, tbl[i][7:0]}, 4'hf, rs);
      axi_write(alu_flags_pkg::CommandAddr, {16'h0, tbl[i][31:16]}, 4'hf, rs);
      check("command bresp", {30'h0, alu_flags_pkg::RespOkay}, {30'h0, rs});
      axi_read(alu_flags_pkg::FlagsAddr, rd, rs);
      check("flags", {27'h0, fm}, rd);
      check("flagsOut", {27'h0, fm}, {27'h0, flagsOut});
      if (tbl[i][24] === 1'b0) begin
        axi_read(alu_flags_pkg::ResultAddr, rd, rs);
        check("result", {24'h0, ex[12:5]}, rd);
      end
    end
    end_of_test();
  end
endmodule : alu_status_flags_bench
